// File: tcpwm_pkg.sv
package tcpwm_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [3:0] REG_STATUS_CTRL = 4'h0;
    localparam logic [3:0] REG_COUNT       = 4'h1;
    localparam logic [3:0] REG_PERIOD      = 4'h2;
    localparam logic [3:0] REG_CH0_CTRL    = 4'h3;
    localparam logic [3:0] REG_CH0_VALUE   = 4'h4;
    localparam logic [3:0] REG_CH1_CTRL    = 4'h5;
    localparam logic [3:0] REG_CH1_VALUE   = 4'h6;

    // ************************************************************
    // Status/control fields
    // ************************************************************
    localparam int SC_WRAP_FLAG = 7;
    localparam int SC_WRAP_IE   = 6;
    localparam int SC_HALT      = 5;
    localparam int SC_CLEAR     = 4;
    localparam int SC_PS_LO     = 0;

    // ************************************************************
    // Channel control fields
    // ************************************************************
    localparam int CC_FLAG   = 7;
    localparam int CC_IE     = 6;
    localparam int CC_MSB    = 5;
    localparam int CC_MSA    = 4;
    localparam int CC_ELSB   = 3;
    localparam int CC_ELSA   = 2;
    localparam int CC_TOV    = 1;
    localparam int CC_MAX    = 0;

    // ************************************************************
    // Reset values and prescaler constants
    // ************************************************************
    localparam logic [7:0]  SC_RESET     = 8'h20;
    localparam logic [7:0]  CC_RESET     = 8'h00;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [2:0]  PS_UNUSED    = 3'h7;
    localparam logic [6:0]  PRESC_MAX    = 7'h7F;
endpackage : tcpwm_pkg

// File: tcpwm_timer.sv
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module tcpwm_timer
    import tcpwm_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // Register port
    input  wire logic [3:0]       regAddr,
    input  wire logic [WIDTH-1:0] regWrData,
    input  wire logic             regWrite,
    input  wire logic             regRead,
    output logic      [WIDTH-1:0] regRdData,
    // System states
    input  wire logic             waitMode,
    input  wire logic             stopMode,
    input  wire logic             breakActive,
    input  wire logic             breakClearPermit,
    // Channel pins
    input  wire logic [1:0]       chanPinIn,
    output logic      [1:0]       chanPinOut,
    output logic      [1:0]       chanPinOe,
    // Requests
    output logic                  wrapIrq,
    output logic      [1:0]       chanIrq,
    output logic                  wakeRequest
);
    if (WIDTH != 16) begin : g_width_check
        $error("tcpwm_timer supports WIDTH 16 only");
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]       scCtrl_q;
    logic [7:0]       chCtrl_q [2];
    logic [WIDTH-1:0] chValue_q [2];
    logic [WIDTH-1:0] period_q;
    logic [WIDTH-1:0] count_q;
    logic [6:0]       presc_q;
    logic             wrapArm_q;
    logic [1:0]       chArm_q;
    logic [1:0]       chLevel_q;
    logic [1:0]       capPrev_q;
    logic             activePair_q;
    logic             pendPair_q;
    logic             pendValid_q;

    logic       tick;
    logic       wrap;
    logic       run;
    logic       buffered;
    logic [1:0] chMatch;
    logic [1:0] capEdge;
    logic [1:0] chOutMode;
    logic [1:0] chCapMode;
    logic [1:0] chEvent;
    logic       clearOk;
    logic       wrClr;
    logic [WIDTH-1:0] cmpValue0;

    assign wrClr    = regWrite && (regAddr == REG_STATUS_CTRL)
                      && regWrData[SC_CLEAR];
    // Stop mode, break and halt bit all freeze the counter
    assign run      = !stopMode && !breakActive
                      && !scCtrl_q[SC_HALT];
    assign clearOk  = !breakActive || breakClearPermit;
    // Buffered select wins over unbuffered select
    assign buffered = chCtrl_q[0][CC_MSB];

    // ************************************************************
    // Prescaler from bus clock only
    // ************************************************************
    always_comb begin
        tick = 1'b0;
        case (scCtrl_q[2:0])
            3'h0: tick = 1'b1;
            3'h1: tick = (presc_q[0:0] == 1'h1);
            3'h2: tick = (presc_q[1:0] == 2'h3);
            3'h3: tick = (presc_q[2:0] == 3'h7);
            3'h4: tick = (presc_q[3:0] == 4'hF);
            3'h5: tick = (presc_q[4:0] == 5'h1F);
            3'h6: tick = (presc_q[5:0] == 6'h3F);
            default: tick = 1'b0;
        endcase
        tick = tick && run;
    end

    always_ff @(posedge clock) begin
        if (!reset_n || wrClr) begin
            presc_q <= 7'h00;
        end else if (run) begin
            presc_q <= presc_q + 7'h01;
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    assign wrap = tick && (count_q == period_q);

    always_ff @(posedge clock) begin
        if (!reset_n || wrClr) begin
            count_q <= '0;
        end else if (wrap) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            period_q <= PERIOD_RESET;
        end else if (regWrite && regAddr == REG_PERIOD) begin
            period_q <= regWrData;
        end
    end

    // ************************************************************
    // Channel modes and events
    // ************************************************************
    // Compare against the currently active pair when linked
    assign cmpValue0 = buffered ? chValue_q[activePair_q]
                                : chValue_q[0];

    generate
        for (genvar c = 0; c < 2; c++) begin : g_chan
            logic lvlSel;
            // Channel 1 is idle while linked
            assign chOutMode[c] = (c == 0) ?
                (buffered || chCtrl_q[0][CC_MSA]) && chCtrl_q[0][3:2] != 2'h0
                : !buffered && chCtrl_q[1][CC_MSA]
                  && chCtrl_q[1][3:2] != 2'h0;
            assign chCapMode[c] = !chCtrl_q[c][CC_MSA] && !chCtrl_q[c][CC_MSB]
                && chCtrl_q[c][3:2] != 2'h0 && !(c == 1 && buffered);
            assign chMatch[c] = tick && (((c == 0) ? cmpValue0
                : chValue_q[1]) == count_q);
            assign capEdge[c] = !breakActive && !stopMode
                && !scCtrl_q[SC_HALT]
                && ((chCtrl_q[c][CC_ELSA] && !capPrev_q[c] && chanPinIn[c])
                 || (chCtrl_q[c][CC_ELSB] && capPrev_q[c] && !chanPinIn[c]));
            assign chEvent[c] = (chOutMode[c] && chMatch[c])
                                || (chCapMode[c] && capEdge[c]);
            assign lvlSel = chCtrl_q[c][CC_ELSA];

            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    capPrev_q[c] <= 1'b0;
                end else begin
                    capPrev_q[c] <= chanPinIn[c];
                end
            end

            // Output level: wrap toggles when TOV is set and MAX is clear, compare forces the ELSA level and beats wrap, TOV with MAX holds !ELSA
            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    chLevel_q[c] <= 1'b0;
                end else if (!chOutMode[c]) begin
                    chLevel_q[c] <= !chCtrl_q[c][CC_MSA];
                end else if (chCtrl_q[c][CC_TOV] && chCtrl_q[c][CC_MAX]) begin
                    chLevel_q[c] <= !lvlSel;
                end else if (chMatch[c]) begin
                    chLevel_q[c] <= lvlSel;
                end else if (wrap && chCtrl_q[c][CC_TOV]) begin
                    chLevel_q[c] <= !chLevel_q[c];
                end
            end

            // Output enable follows the channel mode
            assign chanPinOut[c] = chLevel_q[c];
            assign chanPinOe[c]  = chOutMode[c];

            // Channel flag, cleared by read-while-set then write 0
            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    chArm_q[c] <= 1'b0;
                end else if (chEvent[c]) begin
                    chArm_q[c] <= 1'b0;
                end else if (regRead && clearOk
                             && regAddr == ((c == 0) ? REG_CH0_CTRL
                                                     : REG_CH1_CTRL)
                             && chCtrl_q[c][CC_FLAG]) begin
                    chArm_q[c] <= 1'b1;
                end
            end

            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    chCtrl_q[c] <= CC_RESET;
                end else begin
                    if (regWrite && regAddr == ((c == 0) ? REG_CH0_CTRL
                                                         : REG_CH1_CTRL)) begin
                        chCtrl_q[c][6:0] <= regWrData[6:0];
                        if (!regWrData[CC_FLAG] && chArm_q[c] && clearOk) begin
                            chCtrl_q[c][CC_FLAG] <= 1'b0;
                        end
                    end
                    if (chEvent[c]) begin
                        chCtrl_q[c][CC_FLAG] <= 1'b1;
                    end
                end
            end

            // Capture latches the counter, a write sets compare value
            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    chValue_q[c] <= '0;
                end else if (chCapMode[c] && capEdge[c]) begin
                    chValue_q[c] <= count_q;
                end else if (regWrite && regAddr == ((c == 0) ? REG_CH0_VALUE
                                                      : REG_CH1_VALUE)) begin
                    chValue_q[c] <= regWrData;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Buffered pair selection
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!reset_n || !buffered) begin
            activePair_q <= 1'b0;
            pendPair_q   <= 1'b0;
            pendValid_q  <= 1'b0;
        end else begin
            if (regWrite && regAddr == REG_CH0_VALUE) begin
                pendPair_q  <= 1'b0;
                pendValid_q <= 1'b1;
            end else if (regWrite && regAddr == REG_CH1_VALUE) begin
                pendPair_q  <= 1'b1;
                pendValid_q <= 1'b1;
            end else if (wrap) begin
                pendValid_q <= 1'b0;
            end
            if (wrap && pendValid_q) begin
                activePair_q <= pendPair_q;
            end
        end
    end

    // ************************************************************
    // Status/control and wrap flag
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wrapArm_q <= 1'b0;
        end else if (wrap) begin
            wrapArm_q <= 1'b0;
        end else if (regRead && clearOk && regAddr == REG_STATUS_CTRL
                     && scCtrl_q[SC_WRAP_FLAG]) begin
            wrapArm_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            scCtrl_q <= SC_RESET;
        end else begin
            if (regWrite && regAddr == REG_STATUS_CTRL) begin
                scCtrl_q[SC_WRAP_IE] <= regWrData[SC_WRAP_IE];
                scCtrl_q[SC_HALT]    <= regWrData[SC_HALT];
                scCtrl_q[2:0]        <= regWrData[2:0];
                if (!regWrData[SC_WRAP_FLAG] && wrapArm_q && clearOk) begin
                    scCtrl_q[SC_WRAP_FLAG] <= 1'b0;
                end
            end
            if (wrap) begin
                scCtrl_q[SC_WRAP_FLAG] <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Requests
    // ************************************************************
    // Requests stay live in wait mode and double as wake sources
    assign wrapIrq = scCtrl_q[SC_WRAP_FLAG] && scCtrl_q[SC_WRAP_IE];
    assign chanIrq[0] = chCtrl_q[0][CC_FLAG] && chCtrl_q[0][CC_IE];
    assign chanIrq[1] = chCtrl_q[1][CC_FLAG] && chCtrl_q[1][CC_IE]
                        && !buffered;
    assign wakeRequest = waitMode && (wrapIrq || (|chanIrq));

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            regRdData <= '0;
        end else if (regRead) begin
            if (regAddr == REG_STATUS_CTRL) begin
                regRdData <= {8'h00, scCtrl_q & 8'hEF};
            end else if (regAddr == REG_COUNT) begin
                regRdData <= count_q;
            end else if (regAddr == REG_PERIOD) begin
                regRdData <= period_q;
            end else if (regAddr == REG_CH0_CTRL) begin
                regRdData <= {8'h00, chCtrl_q[0]};
            end else if (regAddr == REG_CH0_VALUE) begin
                regRdData <= chValue_q[0];
            end else if (regAddr == REG_CH1_CTRL) begin
                regRdData <= {8'h00, chCtrl_q[1]};
            end else if (regAddr == REG_CH1_VALUE) begin
                regRdData <= chValue_q[1];
            end else begin
                regRdData <= '0;
            end
        end else begin
            regRdData <= '0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_wrap_sets_flag: assert property (@(posedge clock) disable iff (!reset_n)
        wrap |=> scCtrl_q[SC_WRAP_FLAG])
        else $error("wrap did not set flag");
    a_wrap_zeroes_count: assert property (@(posedge clock) disable iff (!reset_n)
        wrap && !wrClr |=> count_q == 16'h0000)
        else $error("counter not zero after wrap");
    a_stop_freezes: assert property (@(posedge clock) disable iff (!reset_n)
        stopMode && !wrClr |=> $stable(count_q))
        else $error("counter moved in stop");
    a_break_freezes: assert property (@(posedge clock) disable iff (!reset_n)
        breakActive && !wrClr |=> $stable(count_q))
        else $error("counter moved in break");
    a_wrap_flag_cause: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(scCtrl_q[SC_WRAP_FLAG]) |-> $past(wrap))
        else $error("wrap flag set without wrap");
    a_flag_protect: assert property (@(posedge clock) disable iff (!reset_n)
        breakActive && !breakClearPermit && scCtrl_q[SC_WRAP_FLAG]
        |=> scCtrl_q[SC_WRAP_FLAG])
        else $error("flag cleared in protected break");
    sequence s_full_duty_set;
        chOutMode[0] && chCtrl_q[0][CC_TOV] && chCtrl_q[0][CC_MAX];
    endsequence
    sequence s_full_duty_held;
        s_full_duty_set ##1 chOutMode[0] && $stable(chCtrl_q[0]);
    endsequence
    a_full_duty: assert property (@(posedge clock) disable iff (!reset_n)
        s_full_duty_held
        |-> chanPinOut[0] == !chCtrl_q[0][CC_ELSA])
        else $error("full duty level wrong");
    a_match_level: assert property (@(posedge clock) disable iff (!reset_n)
        chOutMode[0] && chMatch[0] && !chCtrl_q[0][CC_MAX]
        && !(regWrite && regAddr == REG_CH0_CTRL)
        |=> chanPinOut[0] == $past(chCtrl_q[0][CC_ELSA]))
        else $error("compare level wrong");
    a_buf_ch1_off: assert property (@(posedge clock) disable iff (!reset_n)
        buffered |-> !chanPinOe[1] && !chanIrq[1])
        else $error("channel 1 active while linked");
endmodule : tcpwm_timer

// File: tcpwm_pin_model.sv
`timescale 1ns/1ps
module tcpwm_pin_model (
    // Clock
    input  wire logic       clock,
    // Channel pins
    input  wire logic [1:0] chanPinOut,
    input  wire logic [1:0] chanPinOe,
    output logic      [1:0] chanPinIn
);
    logic [1:0] wanderLevel_q = 2'h1;

    // No pull resistor: an undriven pin wanders every cycle
    always @(posedge clock) begin
        wanderLevel_q <= ~wanderLevel_q;
    end

    // Driven pins read back, released pins show the wander
    assign chanPinIn = (chanPinOe & chanPinOut)
                     | (~chanPinOe & wanderLevel_q);
endmodule : tcpwm_pin_model

// File: tcpwm_timer_tb.sv
`timescale 1ns/1ps
module tcpwm_timer_tb
    import tcpwm_pkg::*;
;
    localparam int PER = 9;
    logic        clock            = 1'b0;
    logic        reset_n          = 1'b0;
    logic [3:0]  regAddr          = 4'h0;
    logic [15:0] regWrData        = 16'h0;
    logic        regWrite         = 1'b0;
    logic        regRead          = 1'b0;
    logic        waitMode         = 1'b0;
    logic        stopMode         = 1'b0;
    logic        breakActive      = 1'b0;
    logic        breakClearPermit = 1'b0;
    logic [15:0] regRdData;
    logic [1:0]  chanPinIn;
    logic [1:0]  chanPinOut;
    logic [1:0]  chanPinOe;
    logic        wrapIrq;
    logic [1:0]  chanIrq;
    logic        wakeRequest;
    logic [15:0] expQ[$];
    logic        rdSeen           = 1'b0;
    logic [7:0]  modeCtrl[3]      = '{8'h1E, 8'h18, 8'h1B};
    int          modeHi[3];
    int          mismatches       = 0;
    int          n_compared       = 0;
    int          v0;
    int          v1;

    tcpwm_timer #(.WIDTH(16)) uut (
        .clock(clock), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .waitMode(waitMode), .stopMode(stopMode),
        .breakActive(breakActive), .breakClearPermit(breakClearPermit),
        .chanPinIn(chanPinIn), .chanPinOut(chanPinOut),
        .chanPinOe(chanPinOe), .wrapIrq(wrapIrq), .chanIrq(chanIrq),
        .wakeRequest(wakeRequest)
    );

    tcpwm_pin_model pins (
        .clock(clock), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe),
        .chanPinIn(chanPinIn)
    );

    initial forever #5 clock = ~clock;

    // ************************************************************
    // Checking
    // ************************************************************
    task automatic report(bit ok, logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (!ok) begin
            mismatches++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : report

    task automatic cmpReg(logic [15:0] got, logic [15:0] exp);
        report(got === exp, 32'(got), 32'(exp));
    endtask : cmpReg

    task automatic cmpLvl(logic [1:0] got, logic [1:0] exp);
        report(got === exp, 32'(got), 32'(exp));
    endtask : cmpLvl

    task automatic cmpCnt(int got, int exp);
        report(got == exp, 32'(got), 32'(exp));
    endtask : cmpCnt

    task automatic print_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // Read data stand only in the cycle after the strobe
    always @(posedge clock) rdSeen <= regRead;
    always @(negedge clock) begin
        if (rdSeen && expQ.size() > 0) begin
            cmpReg(regRdData, expQ.pop_front());
        end
    end

    initial begin
        #500000;
        mismatches++;
        print_verdict();
    end

    // ************************************************************
    // Stimulus
    // ************************************************************
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clock);
        regWrite  <= 1'b0;
    endtask : wr

    task automatic rd(logic [3:0] a, logic [15:0] e);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        expQ.push_back(e);
        @(posedge clock);
        regRead <= 1'b0;
    endtask : rd

    // Settle two periods, then count high cycles over four periods
    task automatic measure(int ps, int hi);
        int cnt;
        cnt = 0;
        repeat (2 * (PER + 1) << ps) @(negedge clock);
        repeat (4 * (PER + 1) << ps) begin
            @(negedge clock);
            if (chanPinOut[0] === 1'b1) cnt++;
        end
        cmpCnt(cnt, 4 * hi << ps);
    endtask : measure

    task automatic setup(logic [7:0] ctrl, int v);
        wr(REG_STATUS_CTRL, 16'h0030);
        wr(REG_PERIOD, 16'(PER));
        wr(REG_CH0_VALUE, 16'(v));
        wr(REG_CH0_CTRL, {8'h00, ctrl});
        wr(REG_STATUS_CTRL, 16'h0000);
    endtask : setup

    initial begin
        void'($urandom(32'h66A2));
        v0 = $urandom_range(7, 1);
        v1 = $urandom_range(7, 1);
        modeHi = '{PER - v1, 0, PER + 1};
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rd(REG_STATUS_CTRL, 16'h0020);
        wr(4'hF, 16'h00FF);
        rd(4'hF, 16'h0000);
        setup(8'h5A, v0);
        wr(REG_STATUS_CTRL, 16'h0040);
        measure(0, v0 + 1);
        cmpLvl({wrapIrq, wakeRequest}, 2'b10);
        cmpLvl(chanIrq, 2'b01);
        @(posedge clock);
        waitMode <= 1'b1;
        @(negedge clock);
        cmpLvl({wrapIrq, wakeRequest}, 2'b11);
        wr(REG_STATUS_CTRL, 16'h0000);
        @(negedge clock);
        cmpLvl({wrapIrq, wakeRequest}, 2'b01);
        wr(REG_CH0_VALUE, 16'(v1));
        measure(0, v1 + 1);
        @(posedge clock);
        waitMode <= 1'b0;
        for (int ps = 0; ps < 7; ps++) begin
            wr(REG_STATUS_CTRL, 16'(ps));
            measure(ps, v1 + 1);
        end
        for (int i = 0; i < 3; i++) begin
            setup(modeCtrl[i], v1);
            measure(0, modeHi[i]);
        end
        rd(REG_STATUS_CTRL, 16'h0080);
        repeat (2 * (PER + 1)) @(posedge clock);
        wr(REG_STATUS_CTRL, 16'h0000);
        rd(REG_STATUS_CTRL, 16'h0080);
        @(posedge clock);
        breakActive <= 1'b1;
        wr(REG_STATUS_CTRL, 16'h0000);
        rd(REG_STATUS_CTRL, 16'h0080);
        @(posedge clock);
        breakClearPermit <= 1'b1;
        wr(REG_STATUS_CTRL, 16'h0080);
        rd(REG_STATUS_CTRL, 16'h0080);
        wr(REG_STATUS_CTRL, 16'h0000);
        rd(REG_STATUS_CTRL, 16'h0000);
        repeat (2 * (PER + 1)) @(posedge clock);
        rd(REG_STATUS_CTRL, 16'h0000);
        @(posedge clock);
        breakActive      <= 1'b0;
        breakClearPermit <= 1'b0;
        repeat (2 * (PER + 1)) @(posedge clock);
        rd(REG_STATUS_CTRL, 16'h0080);
        wr(REG_STATUS_CTRL, 16'h0030);
        rd(REG_COUNT, 16'h0000);
        @(posedge clock);
        stopMode <= 1'b1;
        wr(REG_STATUS_CTRL, 16'h0000);
        repeat (3 * (PER + 1)) @(posedge clock);
        rd(REG_COUNT, 16'h0000);
        @(posedge clock);
        stopMode <= 1'b0;
        repeat (2 * (PER + 1)) @(posedge clock);
        rd(REG_STATUS_CTRL, 16'h0080);
        @(posedge clock);
        breakActive <= 1'b1;
        wr(REG_CH1_CTRL, 16'h0004);
        repeat (4) @(posedge clock);
        rd(REG_CH1_CTRL, 16'h0004);
        @(posedge clock);
        breakActive <= 1'b0;
        repeat (4) @(posedge clock);
        rd(REG_CH1_CTRL, 16'h0084);
        wr(REG_CH1_CTRL, 16'h001A);
        setup(8'h3A, 3);
        measure(0, 4);
        cmpLvl(chanPinOe, 2'b01);
        wr(REG_CH1_VALUE, 16'h0006);
        measure(0, 7);
        wr(REG_CH0_VALUE, 16'h0002);
        measure(0, 3);
        print_verdict();
    end
endmodule : tcpwm_timer_tb
